/* File: hdl/fanout_defs.svh */
// Purpose: Timing counts, divider codes and reset values for the clock fan-out control.
// Assumes: clk_sys runs at 100 MHz.
// Notes:   Included by bare name; definitions only.
`ifndef FANOUT_DEFS_SVH
`define FANOUT_DEFS_SVH

// --------------------------------------------------------------------------
// Clock and timing
// --------------------------------------------------------------------------
`define CLK_SYS_MHZ       100
`define LOCK_MAX_MS       10
// Longest acquisition time in clk_sys cycles (exact product, no rounding).
`define LOCK_MAX_CYC      (`LOCK_MAX_MS * 1000 * `CLK_SYS_MHZ)
// Consecutive clean reference periods needed before lock is shown.
`define LOCK_GOOD_PERIODS 4

// --------------------------------------------------------------------------
// Oscillator model and divider
// --------------------------------------------------------------------------
`define HP_W              16
`define HP_INIT           16'h0004
`define HP_MIN            16'h0001
`define HP_MAX            16'hFFFF
// Divider code in which all divided outputs except inverted_out sit low.
`define DIV_HOLD          3'h7
// Divider code reached at a common rising edge of all outputs except inverted_out.
`define DIV_WRAP          3'h0
// Step that advances only the primary and half-rate bits.
`define DIV_STEP_Q        3'h2
`define DIV_STEP_2X       3'h1
`define FB_CNT_W          2

`endif

/* File: hdl/fanout_pkg.sv */
// Purpose: Types shared by the clock fan-out control.
// Assumes: Nothing beyond the constants header.
// Notes:   Pin groups travel as one packed struct.
package fanout_pkg;

	// Operating mode of the distribution network.
	typedef enum logic [1:0] {
		MODE_OFF    = 2'b00,
		MODE_BYPASS = 2'b01,
		MODE_LOOP   = 2'b10
	} mode_e;

	// One bit per clock output pin.
	typedef struct packed {
		logic       double_rate_out;
		logic [4:0] primary_outs;
		logic       inverted_out;
		logic       half_rate_out;
	} clk_pins_s;

endpackage

/* File: hdl/pin_sync.sv */
// Purpose: Three-stage synchroniser for asynchronous pins.
// Assumes: Inputs change slower than clk_sys.
// Notes:   A change is taken once stages two and three agree.
`timescale 1ns/1ns
module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         rstn,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] pin_lvl
);

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] lvl_r;
	logic [W-1:0] agree;

	// Per-bit agreement of the two later stages.
	assign agree   = ~(s2_r ^ s3_r);
	assign pin_lvl = lvl_r;

	// Shift chain; the first stage feeds only the second.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s1_r  <= '0;
			s2_r  <= '0;
			s3_r  <= '0;
			lvl_r <= '0;
		end else begin
			s1_r  <= pin_in;
			s2_r  <= s1_r;
			s3_r  <= s2_r;
			lvl_r <= (agree & s3_r) | (~agree & lvl_r);
		end
	end

endmodule

/* File: hdl/clock_fanout_test_mode_control.sv */
// Purpose: Control logic of a phase-aligned clock fan-out driver with bypass test mode.
// Assumes: All pins are asynchronous to clk_sys; references run well below clk_sys.
// Notes:   The oscillator is a cycle-counting model on clk_sys.
// Notes on behaviour
// - Feedback rising edges align to reference rising edges.
// - Primary feedback gives 1x, 2x, half ratios.
// - Enable low tri-states clocks; lock stays driven.
// - Bypass after enable: divided outputs low until reference falls.
// - Bypass hold: double-rate is inverted reference.
// - Loop disabled: double-rate is the inverted reference; primary and half-rate step on reference falls.
// - Tri-state in loop mode drops phase alignment.
// - Alignment regained within 10 ms after enable.
`timescale 1ns/1ns
`include "fanout_defs.svh"
module clock_fanout_test_mode_control #(
	parameter int LOCK_CYCLES  = `LOCK_MAX_CYC,
	parameter int GOOD_PERIODS = `LOCK_GOOD_PERIODS
) (
	input  wire logic                 clk_sys,
	input  wire logic                 rstn,
	input  wire logic                 ref_in_a,
	input  wire logic                 ref_in_b,
	input  wire logic                 ref_sel,
	input  wire logic                 loop_return,
	input  wire logic                 oe_rst_n,
	input  wire logic                 loop_en,
	output fanout_pkg::clk_pins_s     clk_out,
	output fanout_pkg::clk_pins_s     clk_oe,
	output logic                      lock_out
);
	import fanout_pkg::*;

	// ----------------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------------
	localparam int ACQ_W  = $clog2(LOCK_CYCLES + 1);
	localparam int GOOD_W = $clog2(GOOD_PERIODS + 1);
	localparam int PER_W  = `HP_W + 2;

	if (LOCK_CYCLES < 2) begin : g_bad_lock
		$error("LOCK_CYCLES must be at least 2");
	end
	if (GOOD_PERIODS < 1 || GOOD_PERIODS > 255) begin : g_bad_good
		$error("GOOD_PERIODS must be 1 to 255");
	end

	// ----------------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------------
	logic [5:0] pins_s;

	pin_sync #(
		.W (6)
	) u_sync (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.pin_in  ({ref_in_a, ref_in_b, ref_sel, loop_return, oe_rst_n, loop_en}),
		.pin_lvl (pins_s)
	);

	// ----------------------------------------------------------------------
	// Decoding
	// ----------------------------------------------------------------------
	logic                  ref_d_r;
	logic                  fb_d_r;
	logic                  hold_r;
	logic [2:0]            div_r;
	logic [`HP_W-1:0]      tick_r;
	logic [`HP_W-1:0]      hp_r;
	logic [`FB_CNT_W-1:0]  fb_cnt_r;
	logic [GOOD_W-1:0]     good_r;
	logic [ACQ_W-1:0]      acq_r;
	logic [PER_W-1:0]      per_cnt_r;
	clk_pins_s             out_r;
	clk_pins_s             oe_r;
	logic                  lock_r;

	wire       ref_s    = pins_s[3] ? pins_s[4] : pins_s[5];
	wire       fb_s     = pins_s[2];
	wire       oe_s     = pins_s[1];
	wire       en_s     = pins_s[0];
	wire       ref_rise = ref_s & ~ref_d_r;
	wire       ref_fall = ~ref_s & ref_d_r;
	wire       fb_rise  = fb_s & ~fb_d_r;
	wire mode_e mode    = !oe_s ? MODE_OFF : (en_s ? MODE_LOOP : MODE_BYPASS);
	wire       loop_on  = (mode == MODE_LOOP);
	wire       tick_end = (tick_r >= hp_r - `HP_MIN);
	wire       fb_one   = (fb_cnt_r == `FB_CNT_W'(1));
	// The oscillator aims at a quarter of the measured reference period, so
	// the double, primary and half outputs keep their true ratios between
	// reference rises instead of only being re-phased at each rise.
	wire [`HP_W-1:0] hp_tgt = per_cnt_r[PER_W-1:2];
	wire       per_ok   = (per_cnt_r != '0);
	wire       hp_short = per_ok && (hp_r < hp_tgt);
	wire       hp_long  = per_ok && (hp_r > hp_tgt) && (hp_r != `HP_MIN);
	wire       hp_hit   = per_ok && (hp_r == hp_tgt);
	wire       acq_end  = (acq_r == ACQ_W'(LOCK_CYCLES - 1));
	wire       aligned  = (good_r == GOOD_W'(GOOD_PERIODS));

	// Divider step: loop mode ticks the oscillator, bypass steps on falling reference.
	logic [2:0] div_nxt;
	always_comb begin
		div_nxt = div_r;
		case (mode)
			MODE_OFF:    div_nxt = `DIV_HOLD;
			MODE_LOOP: begin
				// A reference rise restarts the primary phase; the half-rate bit
				// toggles only if the oscillator had not yet wrapped on its own.
				if (ref_rise)
					div_nxt = {div_r[2] ^ div_r[1], 2'h0};
				else if (tick_end)
					div_nxt = div_r + `DIV_STEP_2X;
			end
			MODE_BYPASS: begin
				if (ref_fall)
					div_nxt = (hold_r ? `DIV_HOLD : div_r) + `DIV_STEP_Q;
			end
			default:     div_nxt = `DIV_HOLD;
		endcase
	end

	// Output pin values; primary, half-rate and loop-mode double-rate are inverted divider bits.
	clk_pins_s out_nxt;
	clk_pins_s oe_nxt;
	assign out_nxt.double_rate_out = loop_on ? ~div_nxt[0] : (oe_s & ~ref_s);
	assign out_nxt.primary_outs    = {5{oe_s & ~div_nxt[1]}};
	assign out_nxt.inverted_out    = oe_s & div_nxt[1] & ~(hold_r & ~ref_fall & ~loop_on);
	assign out_nxt.half_rate_out   = oe_s & ~div_nxt[2];
	assign oe_nxt                  = {$bits(clk_pins_s){oe_s}};

	// Oscillator half period: one step per reference period toward the target.
	logic [`HP_W-1:0] hp_nxt;
	always_comb begin
		hp_nxt = hp_r;
		if (loop_on && acq_end && !aligned)
			hp_nxt = `HP_INIT;
		else if (loop_on && ref_rise && hp_short)
			hp_nxt = hp_r + `HP_MIN;
		else if (loop_on && ref_rise && hp_long)
			hp_nxt = hp_r - `HP_MIN;
	end

	// ----------------------------------------------------------------------
	// Edge history and bypass hold
	// ----------------------------------------------------------------------

	// Hold is armed while outputs are off and released by a falling reference or by loop enable.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ref_d_r <= 1'b0;
			fb_d_r  <= 1'b0;
			hold_r  <= 1'b1;
		end else begin
			ref_d_r <= ref_s;
			fb_d_r  <= fb_s;
			hold_r  <= !oe_s | (hold_r & !en_s & !ref_fall);
		end
	end

	// ----------------------------------------------------------------------
	// Oscillator model
	// ----------------------------------------------------------------------

	// Tick counter restarts at each reference rise so the outputs rise with it.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			div_r  <= `DIV_HOLD;
			tick_r <= '0;
			hp_r   <= `HP_INIT;
		end else begin
			div_r  <= div_nxt;
			tick_r <= (!loop_on || ref_rise || tick_end) ? '0 : tick_r + `HP_MIN;
			hp_r   <= hp_nxt;
		end
	end

	// ----------------------------------------------------------------------
	// Alignment detection
	// ----------------------------------------------------------------------

	// Feedback edges are counted per reference period; clean periods build lock.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			fb_cnt_r <= '0;
			good_r   <= '0;
			acq_r    <= '0;
		end else if (!loop_on) begin
			fb_cnt_r <= '0;
			good_r   <= '0;
			acq_r    <= '0;
		end else begin
			if (ref_rise)
				fb_cnt_r <= fb_rise ? `FB_CNT_W'(1) : '0;
			else if (fb_rise && fb_cnt_r != '1)
				fb_cnt_r <= fb_cnt_r + `FB_CNT_W'(1);
			if (ref_rise && !(fb_one && hp_hit))
				good_r <= '0;
			else if (ref_rise && !aligned)
				good_r <= good_r + GOOD_W'(1);
			acq_r <= (aligned || acq_end) ? '0 : acq_r + ACQ_W'(1);
		end
	end

	// Reference period in clk_sys cycles; zero until the first rise in loop mode,
	// so a partial first period never steers the oscillator.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			per_cnt_r <= '0;
		else if (!loop_on)
			per_cnt_r <= '0;
		else if (ref_rise)
			per_cnt_r <= PER_W'(1);
		else if (per_ok && per_cnt_r != '1)
			per_cnt_r <= per_cnt_r + PER_W'(1);
	end

	// ----------------------------------------------------------------------
	// Output registers
	// ----------------------------------------------------------------------

	// Every pin is registered; lock is driven in all modes.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			out_r  <= '0;
			oe_r   <= '0;
			lock_r <= 1'b0;
		end else begin
			out_r  <= out_nxt;
			oe_r   <= oe_nxt;
			lock_r <= loop_on & aligned;
		end
	end

	assign clk_out  = out_r;
	assign clk_oe   = oe_r;
	assign lock_out = lock_r;

endmodule

/* File: tb/fanout_board.sv */
// Purpose: Board model: reference source and fed-back load.
// Assumes: Reference steps on falling clk_sys edges.
// Notes: Reference B is the complement of A.
`timescale 1ns/1ns
module fanout_board #(
	parameter int HALF = 20
) (
	input  wire logic                  clk_sys,
	input  wire logic                  run,
	input  wire fanout_pkg::clk_pins_s clk_out,
	input  wire fanout_pkg::clk_pins_s clk_oe,
	output logic                       ref_in_a,
	output logic                       ref_in_b,
	output logic                       loop_return
);
	int cnt = 0;
	initial ref_in_a = 1'b1;
	// The reference toggles every HALF cycles while run is high and holds otherwise.
	always @(negedge clk_sys) begin
		cnt = run ? cnt + 1 : 0;
		if (cnt == HALF) begin
			ref_in_a <= ~ref_in_a;
			cnt = 0;
		end
	end
	assign ref_in_b = ~ref_in_a;
	// A pull-down holds the loop input low while the fed-back pin floats.
	assign loop_return = clk_oe.primary_outs[0] ? clk_out.primary_outs[0] : 1'b0;
endmodule

/* File: tb/clock_fanout_test_mode_control_assertions.sv */
// Purpose: Port checks of the clock fan-out control.
// Assumes: Pins reach the outputs within six clk_sys edges.
// Notes: Bound to every instance of the top module.
`timescale 1ns/1ns
module fanout_checker import fanout_pkg::*; #(
	parameter int LOCK_CYCLES = 2000
) (
	input wire logic      clk_sys,
	input wire logic      rstn,
	input wire logic      ref_in_a,
	input wire logic      ref_in_b,
	input wire logic      ref_sel,
	input wire logic      loop_return,
	input wire logic      oe_rst_n,
	input wire logic      loop_en,
	input wire clk_pins_s clk_out,
	input wire clk_pins_s clk_oe,
	input wire logic      lock_out
);
	localparam int SLACK = 200;
	int wait_r;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// Counts cycles of loop activity spent without lock.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			wait_r <= 0;
		else
			wait_r <= (loop_en && oe_rst_n && !lock_out) ? wait_r + 1 : 0;
	end
	AST_OE_OFF: assert property (!oe_rst_n [*7] |-> clk_oe == 8'h00 && clk_out == 8'h00)
		else $error("Clock pins driven while disabled");
	AST_OE_UNIFORM: assert property (clk_oe == 8'h00 || clk_oe == 8'hFF)
		else $error("Output enables disagree");
	AST_HOLD_LOW: assert property ((!loop_en && !ref_sel && ref_in_a && !oe_rst_n) [*4] ##1
		(!loop_en && !ref_sel && ref_in_a && oe_rst_n) [*8] |-> clk_out[6:0] == 7'h00)
		else $error("Divided outputs left hold early");
	AST_DOUBLE_INV: assert property ((!loop_en && oe_rst_n && !ref_sel && ref_in_a) [*8]
		|-> clk_oe.double_rate_out && !clk_out.double_rate_out)
		else $error("Double-rate pin not the inverse reference");
	AST_PRIM_SAME: assert property (clk_out.primary_outs inside {5'h00, 5'h1F})
		else $error("Primary pins differ");
	AST_INV_LOOP: assert property ((loop_en && oe_rst_n) [*8]
		|-> clk_out.inverted_out != clk_out.primary_outs[0])
		else $error("Inverted pin equals primary");
	AST_LOCK_LOST: assert property (!oe_rst_n [*7] |-> !lock_out)
		else $error("Lock kept with outputs off");
	AST_LOCK_BYPASS: assert property (!loop_en [*7] |-> !lock_out)
		else $error("Lock shown in bypass");
	AST_LOCK_TIME: assert property (wait_r <= LOCK_CYCLES + SLACK)
		else $error("Lock not reached in time");
	cover property ($rose(lock_out));
	cover property ($rose(clk_out.primary_outs[0]) && !loop_en);
	cover property ($fell(clk_oe.double_rate_out));
endmodule
bind clock_fanout_test_mode_control fanout_checker #(.LOCK_CYCLES(LOCK_CYCLES)) chk (
	.clk_sys(clk_sys), .rstn(rstn), .ref_in_a(ref_in_a), .ref_in_b(ref_in_b),
	.ref_sel(ref_sel), .loop_return(loop_return), .oe_rst_n(oe_rst_n),
	.loop_en(loop_en), .clk_out(clk_out), .clk_oe(clk_oe), .lock_out(lock_out));

/* File: tb/clock_fanout_test_mode_control_test.sv */
// Purpose: Self-checking bench of the clock fan-out control.
// Assumes: Reference period of 40 clk_sys cycles.
// Notes: Inputs change on falling clk_sys edges.
`timescale 1ns/1ns
module clock_fanout_test_mode_control_test;
	import fanout_pkg::*;
	localparam int LOCK_CYC = 2000;
	logic      clk_sys = 0, rstn = 0, ref_sel = 1, oe_rst_n = 0, loop_en = 0, run = 0;
	logic      ref_in_a, ref_in_b, loop_return, lock_out;
	clk_pins_s clk_out, clk_oe;
	int        error_cnt = 0, num_checks = 0;
	initial forever #5 clk_sys = ~clk_sys;
	clock_fanout_test_mode_control #(.LOCK_CYCLES(LOCK_CYC)) dut (.clk_sys(clk_sys),
		.rstn(rstn), .ref_in_a(ref_in_a), .ref_in_b(ref_in_b), .ref_sel(ref_sel),
		.loop_return(loop_return), .oe_rst_n(oe_rst_n), .loop_en(loop_en),
		.clk_out(clk_out), .clk_oe(clk_oe), .lock_out(lock_out));
	fanout_board #(.HALF(20)) board (.clk_sys(clk_sys), .run(run), .clk_out(clk_out),
		.clk_oe(clk_oe), .ref_in_a(ref_in_a), .ref_in_b(ref_in_b), .loop_return(loop_return));
	// Compares one value and reports a mismatch.
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Bypass: hold after enable, then release on reference falls.
	task automatic t_bypass();
		cyc(10);
		chk("oe off", 8'h00, clk_oe);
		oe_rst_n = 1;
		cyc(10);
		chk("oe on", 8'hFF, clk_oe);
		chk("hold b", 8'h80, clk_out);
		ref_sel = 0;
		cyc(10);
		chk("hold a", 8'h00, clk_out);
		run = 1;
		cyc(28);
		chk("first fall", 8'hFD, clk_out);
		cyc(40);
		chk("second fall", 8'h83, clk_out);
		chk("lock bypass", 8'h00, {7'h00, lock_out});
	endtask
	// Waits for lock within the acquisition limit plus 200 cycles.
	task automatic t_lock();
		int i = 0;
		while (lock_out !== 1'b1 && i < LOCK_CYC + 200) begin
			cyc(1);
			i++;
		end
		chk("lock", 8'h01, {7'h00, lock_out});
	endtask
	// Counts rises over twenty reference periods.
	task automatic t_rates();
		int pr = 0, dr = 0, hr = 0, bad = 0;
		clk_pins_s prev = clk_out;
		repeat (800) begin
			cyc(1);
			pr += int'(clk_out.primary_outs[0] && !prev.primary_outs[0]);
			dr += int'(clk_out.double_rate_out && !prev.double_rate_out);
			hr += int'(clk_out.half_rate_out && !prev.half_rate_out);
			bad += int'(clk_out.inverted_out === clk_out.primary_outs[0]);
			prev = clk_out;
		end
		chk("primary rate", 8'h01, {7'h00, pr inside {[19:21]}});
		chk("double rate", 8'h01, {7'h00, dr inside {[39:41]}});
		chk("half rate", 8'h01, {7'h00, hr inside {[9:11]}});
		chk("inverted", 8'h00, 8'(bad));
	endtask
	// Bypass re-entry: freeze reference A high, pulse enable, then release on a fall.
	task automatic t_rehold();
		@(posedge ref_in_a);
		cyc(2);
		run = 0;
		oe_rst_n = 0;
		cyc(10);
		oe_rst_n = 1;
		cyc(10);
		chk("rehold", 8'h00, clk_out);
		run = 1;
		cyc(28);
		chk("rehold fall", 8'hFD, clk_out);
	endtask
	initial begin
		repeat (15000) @(posedge clk_sys);
		error_cnt++;
		print_verdict();
	end
	initial begin
		cyc(10);
		rstn = 1;
		t_bypass();
		loop_en = 1;
		t_lock();
		t_rates();
		oe_rst_n = 0;
		cyc(10);
		chk("lock lost", 8'h00, {7'h00, lock_out});
		chk("oe off loop", 8'h00, clk_oe);
		oe_rst_n = 1;
		t_lock();
		loop_en = 0;
		cyc(8);
		chk("lock off", 8'h00, {7'h00, lock_out});
		t_rehold();
		print_verdict();
	end
endmodule
